// >>> verilog/dlirp_regs.svh
// Constants for the dual supply controller serial register port
`ifndef DLIRP_REGS_SVH
`define DLIRP_REGS_SVH
`define DLIRP_ADDR_PREFIX   6'h04
`define DLIRP_SEL_MSB       7
`define DLIRP_SEL_LSB       5
`define DLIRP_FIELD_RESET   5'h00
`define DLIRP_SEL_RESET     3'h0
`define DLIRP_MASK_STATUS   5'h00
`define DLIRP_MASK_TONE     5'h1C
`define DLIRP_MASK_CMD      5'h1F
`define DLIRP_MASK_CTRL     5'h13
`define DLIRP_BIT_FORCE     4
`define DLIRP_BIT_EXTMOD    3
`define DLIRP_BIT_THRESH    2
`define DLIRP_BIT_STATIC    4
`define DLIRP_BIT_PINDIS    3
`define DLIRP_BIT_RANGE     2
`define DLIRP_BIT_HIGH      1
`define DLIRP_BIT_LOW       0
`define DLIRP_BIT_ON        4
`define DLIRP_BIT_HTRIM     1
`define DLIRP_BIT_LTRIM     0
`define DLIRP_CLK_NS        100
`define DLIRP_SCL_NS        10000
`define DLIRP_QUARTER       ((`DLIRP_SCL_NS / `DLIRP_CLK_NS) / 4)
`endif

// >>> verilog/dlirp_pkg.sv
// Types shared by both ends of the serial register port
package dlirp_pkg;
   typedef enum logic [2:0] {
      D_IDLE    = 3'b000,
      D_ADDR    = 3'b001,
      D_ADDR_AK = 3'b010,
      D_WR_DATA = 3'b011,
      D_WR_AK   = 3'b100,
      D_RD_DATA = 3'b101,
      D_RD_AK   = 3'b110,
      D_IGNORE  = 3'b111
   } dlirp_dstate_e;
   typedef enum logic [1:0] {
      H_IDLE  = 2'b00,
      H_START = 2'b01,
      H_BIT   = 2'b10,
      H_STOP  = 2'b11
   } dlirp_hstate_e;
   typedef enum logic [2:0] {
      LIM_305    = 3'b000,
      LIM_388    = 3'b001,
      LIM_570    = 3'b010,
      LIM_705    = 3'b011,
      LIM_890    = 3'b100,
      LIM_STATIC = 3'b101
   } dlirp_limit_e;
endpackage : dlirp_pkg

// >>> verilog/dlirp_if.sv
// Open-drain two-wire bus joining host and device
`timescale 1ns/100ps
interface dlirp_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;
   // Wired-AND with pull-up: any enabled low driver wins
   assign scl = !(m_scl_oe && !m_scl_o);
   assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);
   modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
   modport dev  (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface : dlirp_if

// >>> verilog/dlirp_device.sv
// Device end: serial slave and eight-register system map
//
// Functional notes
// - Lines driven open-drain only, idle high
// - Data changes only while clock low
// - Start and stop detected while clock high
// - Master sends stop before each start
// - Eight bits, MSB first, then acknowledge
// - Addressed slave holds data low during acknowledge
// - Master may stop after missing acknowledge
// - No acknowledge while supply-good low
// - Master may skip acknowledge checking
// - Address 000100X, last bit read/write
// - Start, address, one data byte, stop
// - All register bits cleared at reset
// - Top three data bits select register
// - Read-only and unused written bits ignored
// - Selector bits and control field layouts
// - Overload and back-current flags in status
// - Voltage-range and open-cable flags in status
// - Shared over-temperature flag ch1 bit4
// - Tone force and modulation choice set mode
// - Bit 2 selects decoder detect threshold
// - Static or dynamic limit and threshold code
// - Range pin enabled unless disable bit set
`timescale 1ns/100ps
`include "dlirp_regs.svh"
module dlirp_device (
   input  wire logic                  core_clk,                  // Core clock, 10 MHz
   input  wire logic                  sys_rst,                   // Async reset, active high
   dlirp_if.dev                       bus,                       // Two-wire bus
   input  wire logic [1:0]            addr_sel,                  // Address select straps
   input  wire logic                  undervoltage_lockout,      // Supply good, high = ok
   input  wire logic                  over_temp_flag,            // Shared over-temperature
   input  wire logic [1:0]            cable_open_flag,           // Per channel, [0]=ch1
   input  wire logic [1:0]            voltage_range_fault,       // Per channel
   input  wire logic [1:0]            overload_flag,             // Per channel
   input  wire logic [1:0]            back_current_flag,         // Per channel
   input  wire logic                  tone_22k,                  // Internal tone oscillator
   input  wire logic [1:0]            tone_modulation_input,     // External modulation pins
   input  wire logic [1:0]            range_select_pin,          // External range pins
   output logic      [1:0]            tone_force,                // Tone force bits
   output logic      [1:0]            ext_modulation_choice,     // Modulation select bits
   output logic      [1:0]            detect_threshold_choice,   // 1 = transmit threshold
   output logic      [1:0]            static_limit_choice,       // 1 = static limiting
   output logic      [1:0]            range_pin_disable,         // 1 = pin ignored
   output logic      [1:0]            limit_range_bit,           // Limit range bit
   output logic      [1:0]            limit_high_bit,            // Limit high bit
   output logic      [1:0]            limit_low_bit,             // Limit low bit
   output logic      [1:0]            channel_on,                // Channel enable
   output logic      [1:0]            high_range_trim,           // High range trim bit
   output logic      [1:0]            low_range_trim,            // Low range trim bit
   output logic      [1:0]            tone_drive,                // Tone to the output stage
   output dlirp_pkg::dlirp_limit_e    limit_code [2],            // Decoded limit setting
   output logic      [1:0]            high_range_sel,            // Effective high range
   output logic      [1:0]            plus_one_sel               // Effective +1 V step
);
   import dlirp_pkg::*;

   dlirp_dstate_e state;
   logic [2:0]    scl_sy;
   logic [2:0]    sda_sy;
   logic          scl_f;
   logic          sda_f;
   logic          scl_q;
   logic          sda_q;
   logic [3:0]    cnt;
   logic [7:0]    shift;
   logic [7:0]    tx;
   logic          ack_en;
   logic          nack;
   logic [2:0]    last_sel;
   logic [4:0]    bank [8];
   logic          rise;
   logic          fall;
   logic          start_seen;
   logic          stop_seen;
   logic [4:0]    rd_low;
   logic [4:0]    wr_mask;
   logic [2:0]    wr_sel;

   // Three-stage synchronisers; a level counts once stages two and three agree
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_sy <= 3'h7;
         sda_sy <= 3'h7;
      end else begin
         scl_sy <= {scl_sy[1:0], bus.scl};
         sda_sy <= {sda_sy[1:0], bus.sda};
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         if (scl_sy[1] == scl_sy[2]) scl_f <= scl_sy[2];
         if (sda_sy[1] == sda_sy[2]) sda_f <= sda_sy[2];
         scl_q <= scl_f;
         sda_q <= sda_f;
      end
   end

   assign rise       = scl_f && !scl_q;
   assign fall       = !scl_f && scl_q;
   assign start_seen = scl_f && scl_q && sda_q && !sda_f;
   assign stop_seen  = scl_f && scl_q && !sda_q && sda_f;

   assign wr_sel = shift[`DLIRP_SEL_MSB:`DLIRP_SEL_LSB];
   always_comb begin
      case (wr_sel[1:0])
         2'b00:   wr_mask = `DLIRP_MASK_STATUS;
         2'b01:   wr_mask = `DLIRP_MASK_TONE;
         2'b10:   wr_mask = `DLIRP_MASK_CMD;
         default: wr_mask = `DLIRP_MASK_CTRL;
      endcase
   end

   // Status flags are live; control registers return stored fields
   always_comb begin
      if (last_sel == 3'h0) begin
         rd_low = {over_temp_flag, cable_open_flag[0], voltage_range_fault[0],
                   overload_flag[0], back_current_flag[0]};
      end else if (last_sel == 3'h4) begin
         rd_low = {1'b0, cable_open_flag[1], voltage_range_fault[1],
                   overload_flag[1], back_current_flag[1]};
      end else begin
         rd_low = bank[last_sel];
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state  <= D_IDLE;
         cnt    <= 4'h0;
         shift  <= 8'h00;
         tx     <= 8'h00;
         ack_en <= 1'b0;
         nack   <= 1'b0;
      end else if (start_seen) begin
         state <= D_ADDR;
         cnt   <= 4'h0;
      end else if (stop_seen) begin
         state <= D_IDLE;
      end else begin
         case (state)
            D_ADDR, D_WR_DATA: begin
               if (rise) begin
                  shift <= {shift[6:0], sda_f};
                  cnt   <= cnt + 4'h1;
               end else if (fall && cnt == 4'h8) begin
                  ack_en <= undervoltage_lockout;
                  if (state == D_WR_DATA) begin
                     state <= D_WR_AK;
                  // Last byte bit is direction only, so both ways answer; strap bit 0 has no role
                  end else if (shift[7:1] == {`DLIRP_ADDR_PREFIX, addr_sel[1]}) begin
                     state <= D_ADDR_AK;
                  end else begin
                     state <= D_IGNORE;
                  end
               end
            end
            D_ADDR_AK: begin
               if (fall) begin
                  cnt <= 4'h0;
                  if (!ack_en) begin
                     state <= D_IGNORE;
                  end else if (shift[0]) begin
                     state <= D_RD_DATA;
                     tx    <= {last_sel, rd_low};
                  end else begin
                     state <= D_WR_DATA;
                  end
               end
            end
            D_WR_AK: begin
               if (fall) begin
                  cnt   <= 4'h0;
                  state <= D_WR_DATA;
               end
            end
            D_RD_DATA: begin
               if (fall) begin
                  tx  <= {tx[6:0], 1'b1};
                  cnt <= cnt + 4'h1;
                  if (cnt == 4'h7) state <= D_RD_AK;
               end
            end
            D_RD_AK: begin
               if (rise) begin
                  nack <= sda_f;
               end else if (fall) begin
                  cnt <= 4'h0;
                  if (nack) begin
                     state <= D_IGNORE;
                  end else begin
                     state <= D_RD_DATA;
                     tx    <= {last_sel, rd_low};
                  end
               end
            end
            default: state <= state;
         endcase
      end
   end

   // Register write at the end of a data byte, only when acknowledged
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_sel <= `DLIRP_SEL_RESET;
         for (int i = 0; i < 8; i++) bank[i] <= `DLIRP_FIELD_RESET;
      end else if (state == D_WR_DATA && fall && cnt == 4'h8 && undervoltage_lockout && !start_seen && !stop_seen) begin
         last_sel     <= wr_sel;
         bank[wr_sel] <= (bank[wr_sel] & ~wr_mask) | (shift[4:0] & wr_mask);
      end
   end

   // Open-drain data: only ever pulls low
   assign bus.s_sda_o  = 1'b0;
   // Supply loss drops the pull at once, even inside an acknowledge slot
   assign bus.s_sda_oe = undervoltage_lockout
                       && (((state == D_ADDR_AK || state == D_WR_AK) && ack_en)
                       || (state == D_RD_DATA && !tx[7]));

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               tone_force[ch]              <= 1'b0;
               ext_modulation_choice[ch]   <= 1'b0;
               detect_threshold_choice[ch] <= 1'b0;
               static_limit_choice[ch]     <= 1'b0;
               range_pin_disable[ch]       <= 1'b0;
               limit_range_bit[ch]         <= 1'b0;
               limit_high_bit[ch]          <= 1'b0;
               limit_low_bit[ch]           <= 1'b0;
               channel_on[ch]              <= 1'b0;
               high_range_trim[ch]         <= 1'b0;
               low_range_trim[ch]          <= 1'b0;
               tone_drive[ch]              <= 1'b0;
               limit_code[ch]              <= LIM_305;
               high_range_sel[ch]          <= 1'b0;
               plus_one_sel[ch]            <= 1'b0;
            end else begin
               tone_force[ch]              <= bank[ch*4+1][`DLIRP_BIT_FORCE];
               ext_modulation_choice[ch]   <= bank[ch*4+1][`DLIRP_BIT_EXTMOD];
               detect_threshold_choice[ch] <= bank[ch*4+1][`DLIRP_BIT_THRESH];
               static_limit_choice[ch]     <= bank[ch*4+2][`DLIRP_BIT_STATIC];
               range_pin_disable[ch]       <= bank[ch*4+2][`DLIRP_BIT_PINDIS];
               limit_range_bit[ch]         <= bank[ch*4+2][`DLIRP_BIT_RANGE];
               limit_high_bit[ch]          <= bank[ch*4+2][`DLIRP_BIT_HIGH];
               limit_low_bit[ch]           <= bank[ch*4+2][`DLIRP_BIT_LOW];
               channel_on[ch]              <= bank[ch*4+3][`DLIRP_BIT_ON];
               high_range_trim[ch]         <= bank[ch*4+3][`DLIRP_BIT_HTRIM];
               low_range_trim[ch]          <= bank[ch*4+3][`DLIRP_BIT_LTRIM];
               // Mode 11 is undefined; treated as forced tone
               if (bank[ch*4+1][`DLIRP_BIT_FORCE:`DLIRP_BIT_EXTMOD] == 2'b01) begin
                  tone_drive[ch] <= tone_modulation_input[ch];
               end else if (bank[ch*4+1][`DLIRP_BIT_FORCE]) begin
                  tone_drive[ch] <= tone_22k;
               end else begin
                  tone_drive[ch] <= tone_22k && tone_modulation_input[ch];
               end
               if (bank[ch*4+2][`DLIRP_BIT_STATIC]) begin
                  limit_code[ch] <= LIM_STATIC;
               end else if (!bank[ch*4+2][`DLIRP_BIT_RANGE]) begin
                  limit_code[ch] <= LIM_305;
               end else begin
                  limit_code[ch] <= dlirp_limit_e'({1'b0, bank[ch*4+2][1:0]} + 3'h1);
               end
               if (bank[ch*4+2][`DLIRP_BIT_PINDIS]) begin
                  high_range_sel[ch] <= bank[ch*4+3][`DLIRP_BIT_HTRIM];
                  plus_one_sel[ch]   <= bank[ch*4+3][`DLIRP_BIT_LTRIM];
               end else begin
                  high_range_sel[ch] <= range_select_pin[ch];
                  plus_one_sel[ch]   <= range_select_pin[ch] ? bank[ch*4+3][`DLIRP_BIT_HTRIM]
                                                             : bank[ch*4+3][`DLIRP_BIT_LTRIM];
               end
            end
         end
      end
   endgenerate
endmodule : dlirp_device

// >>> verilog/dlirp_host.sv
// Host end: bus master issuing one-byte register transactions
`timescale 1ns/100ps
`include "dlirp_regs.svh"
module dlirp_host (
   input  wire logic       core_clk,     // Core clock, 10 MHz
   input  wire logic       sys_rst,      // Async reset, active high
   dlirp_if.host           bus,          // Two-wire bus
   input  wire logic       cmd_start,    // Pulse: begin a transaction
   input  wire logic       cmd_read,     // 1 = read, 0 = write
   input  wire logic [1:0] cmd_addr_sel, // Device address select bits
   input  wire logic [7:0] cmd_wdata,    // Byte to write
   output logic            busy,         // Transaction in progress
   output logic            done,         // Pulse: transaction finished
   output logic [7:0]      rd_data,      // Byte read back
   output logic            ack_fail      // Missing acknowledge seen
);
   import dlirp_pkg::*;

   localparam logic [4:0] QUARTER_M1 = 5'(`DLIRP_QUARTER - 1);

   dlirp_hstate_e state;
   logic [4:0]    qcnt;
   logic [1:0]    phase;
   logic [3:0]    bitn;
   logic          byten;
   logic          rd_mode;
   logic [7:0]    wbuf;
   logic [7:0]    tx;
   logic [2:0]    sda_sy;
   logic          sda_f;
   logic          tick;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sda_sy <= 3'h7;
         sda_f  <= 1'b1;
      end else begin
         sda_sy <= {sda_sy[1:0], bus.sda};
         if (sda_sy[1] == sda_sy[2]) sda_f <= sda_sy[2];
      end
   end

   // Quarter-bit divider makes the clock line
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         qcnt <= 5'h00;
      end else if (state == H_IDLE || tick) begin
         qcnt <= 5'h00;
      end else begin
         qcnt <= qcnt + 5'h01;
      end
   end
   assign tick = (qcnt == QUARTER_M1);

   assign bus.m_scl_o = 1'b0;
   assign bus.m_sda_o = 1'b0;
   assign busy        = (state != H_IDLE);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state        <= H_IDLE;
         phase        <= 2'h0;
         bitn         <= 4'h0;
         byten        <= 1'b0;
         rd_mode      <= 1'b0;
         wbuf         <= 8'h00;
         tx           <= 8'h00;
         rd_data      <= 8'h00;
         ack_fail     <= 1'b0;
         done         <= 1'b0;
         bus.m_scl_oe <= 1'b0;
         bus.m_sda_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         if (state == H_IDLE) begin
            if (cmd_start) begin
               state    <= H_START;
               phase    <= 2'h0;
               rd_mode  <= cmd_read;
               wbuf     <= cmd_wdata;
               tx       <= {`DLIRP_ADDR_PREFIX, cmd_addr_sel[1], cmd_read};
               ack_fail <= 1'b0;
            end
         end else if (tick) begin
            phase <= phase + 2'h1;
            case (state)
               H_START: begin
                  if (phase == 2'h1) bus.m_sda_oe <= 1'b1;
                  if (phase == 2'h3) begin
                     bus.m_scl_oe <= 1'b1;
                     state        <= H_BIT;
                     bitn         <= 4'h0;
                     byten        <= 1'b0;
                  end
               end
               H_BIT: begin
                  case (phase)
                     2'h0: bus.m_sda_oe <= (bitn != 4'h8) && !tx[7];
                     2'h1: bus.m_scl_oe <= 1'b0;
                     2'h2: begin
                        if (bitn == 4'h8 && (!byten || !rd_mode) && sda_f) ack_fail <= 1'b1;
                        if (bitn != 4'h8 && byten && rd_mode) rd_data <= {rd_data[6:0], sda_f};
                     end
                     default: begin
                        bus.m_scl_oe <= 1'b1;
                        if (bitn != 4'h8) begin
                           bitn <= bitn + 4'h1;
                           tx   <= {tx[6:0], 1'b1};
                        end else if (byten || ack_fail) begin
                           state <= H_STOP;
                        end else begin
                           byten <= 1'b1;
                           bitn  <= 4'h0;
                           tx    <= rd_mode ? 8'hFF : wbuf;
                        end
                     end
                  endcase
               end
               H_STOP: begin
                  case (phase)
                     2'h0: bus.m_sda_oe <= 1'b1;
                     2'h1: bus.m_scl_oe <= 1'b0;
                     2'h2: bus.m_sda_oe <= 1'b0;
                     default: begin
                        state <= H_IDLE;
                        done  <= 1'b1;
                     end
                  endcase
               end
               default: state <= H_IDLE;
            endcase
         end
      end
   end
endmodule : dlirp_host

// >>> verif/dlirp_chk.sv
// Protocol checks on the shared two-wire bus
`timescale 1ns/100ps
module dlirp_chk (
   input wire logic core_clk,             // Core clock
   input wire logic sys_rst,              // Async reset
   input wire logic scl,                  // Resolved clock line
   input wire logic sda,                  // Resolved data line
   input wire logic m_scl_o,              // Host clock level
   input wire logic m_scl_oe,             // Host clock pull
   input wire logic m_sda_o,              // Host data level
   input wire logic m_sda_oe,             // Host data pull
   input wire logic s_sda_o,              // Device data level
   input wire logic s_sda_oe,             // Device data pull
   input wire logic undervoltage_lockout  // Supply good
);
   logic       scl_q;
   logic       sda_q;
   logic       in_frame;
   logic [4:0] nbits;
   wire        sta = scl && scl_q && sda_q && !sda;
   wire        stp = scl && scl_q && !sda_q && sda;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   // Stop clock rise counts too, so a full frame is 19
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_frame <= 1'b0;
         nbits <= 5'h00;
      end else if (sta) begin
         in_frame <= 1'b1;
         nbits <= 5'h00;
      end else if (stp) begin
         in_frame <= 1'b0;
      end else if (scl && !scl_q && in_frame) begin
         nbits <= nbits + 5'h01;
      end
   end
   sequence held_low;
      (s_sda_oe && !sda)[*8];
   endsequence
   open_drain_a:
      assert property (!(m_scl_oe && m_scl_o) && !(m_sda_oe && m_sda_o) && !(s_sda_oe && s_sda_o)) else $error("high drive");
   rst_idle_a:
      assert property ($fell(sys_rst) |-> scl && sda && !s_sda_oe) else $error("bus not idle");
   idle_quiet_a:
      assert property (!in_frame |-> !s_sda_oe) else $error("device drives idle bus");
   dev_hold_a:
      assert property ($changed(s_sda_oe) |-> !scl) else $error("device data moved, clock high");
   scl_high_a:
      assert property ($rose(scl) |-> (scl && $stable(sda))[*8]) else $error("data moved in high phase");
   stop_first_a:
      assert property (sta |-> !in_frame) else $error("start without stop");
   byte_count_a:
      assert property (stp |-> nbits == 5'h13 || nbits == 5'h0A) else $error("bad pulse count");
   ack_low_a:
      assert property ($rose(scl) && s_sda_oe |-> held_low) else $error("ack not held low");
   lockout_a:
      assert property (!undervoltage_lockout |-> !s_sda_oe) else $error("ack under lockout");
endmodule : dlirp_chk

// >>> verif/dual_lnb_i2c_register_port_tb.sv
// Bench: host and device ends joined over the two-wire bus
`timescale 1ns/100ps
module dual_lnb_i2c_register_port_tb;
   import dlirp_pkg::*;
   logic         core_clk, sys_rst, busy, done, ack_fail;
   logic         cmd_start = 1'b0;
   logic         cmd_read = 1'b0;
   logic         undervoltage_lockout = 1'b1;
   logic         tone_22k = 1'b0;
   logic [1:0]   ext_mod = 2'b00;
   logic [1:0]   addr_sel = 2'b00;
   logic [1:0]   cmd_addr_sel = 2'b00;
   logic [7:0]   cmd_wdata = 8'h00;
   logic [7:0]   rd_data;
   logic [8:0]   flags = 9'h199;
   logic [1:0]   tone_force, static_limit_choice, range_pin_disable, channel_on, tone_drive;
   logic [1:0]   detect_threshold_choice, high_range_sel;
   logic [1:0]   range_sel = 2'b00;
   dlirp_limit_e limit_code [2];
   int           err_count = 0;
   int           n_tests = 0;
   dlirp_if bus ();
   dlirp_host u_dlirp_host (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus.host), .cmd_start(cmd_start),
      .cmd_read(cmd_read), .cmd_addr_sel(cmd_addr_sel), .cmd_wdata(cmd_wdata), .busy(busy), .done(done),
      .rd_data(rd_data), .ack_fail(ack_fail));
   dlirp_device u_dlirp_device (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus.dev), .addr_sel(addr_sel),
      .undervoltage_lockout(undervoltage_lockout), .over_temp_flag(flags[8]), .cable_open_flag(flags[7:6]),
      .voltage_range_fault(flags[5:4]), .overload_flag(flags[3:2]), .back_current_flag(flags[1:0]),
      .tone_22k(tone_22k), .tone_modulation_input(ext_mod), .range_select_pin(range_sel), .tone_force(tone_force),
      .ext_modulation_choice(), .detect_threshold_choice(detect_threshold_choice),
      .static_limit_choice(static_limit_choice),
      .range_pin_disable(range_pin_disable), .limit_range_bit(), .limit_high_bit(), .limit_low_bit(),
      .channel_on(channel_on), .high_range_trim(), .low_range_trim(), .tone_drive(tone_drive),
      .limit_code(limit_code), .high_range_sel(high_range_sel), .plus_one_sel());
   dlirp_chk u_dlirp_chk (.core_clk(core_clk), .sys_rst(sys_rst), .scl(bus.scl), .sda(bus.sda),
      .m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe), .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe),
      .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .undervoltage_lockout(undervoltage_lockout));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic xfer(input logic rd, input logic [1:0] asel, input logic [7:0] wd);
      cmd_read = rd;
      cmd_addr_sel = asel;
      cmd_wdata = wd;
      cmd_start = 1'b1;
      @(negedge core_clk);
      cmd_start = 1'b0;
      for (int n = 0; n < 2200 && done !== 1'b1; n++) begin
         @(negedge core_clk);
      end
      chk(done, 8'h01);
      chk({7'h00, busy}, 8'h00);
      @(negedge core_clk);
   endtask : xfer
   task automatic t_reset;
      chk({5'h00, limit_code[0]}, {5'h00, LIM_305});
      xfer(1'b1, 2'b01, 8'h00);
      chk(rd_data, 8'h15);
   endtask : t_reset
   task automatic t_map;
      logic [7:0] exp [8] = '{8'h15, 8'h3C, 8'h5F, 8'h73, 8'h8A, 8'hBC, 8'hDF, 8'hF3};
      for (int i = 0; i < 8; i++) begin
         xfer(1'b0, 2'b00, {i[2:0], 5'h1F});
         xfer(1'b1, 2'b01, 8'h00);
         chk(rd_data, exp[i]);
      end
      chk({tone_force, static_limit_choice, range_pin_disable, channel_on}, 8'hFF);
      chk({6'h00, detect_threshold_choice}, 8'h03);
   endtask : t_map
   task automatic t_limit;
      logic [2:0]   code [5] = '{3'b011, 3'b100, 3'b101, 3'b110, 3'b111};
      dlirp_limit_e exp [5] = '{LIM_305, LIM_388, LIM_570, LIM_705, LIM_890};
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, 2'b00, {5'b01000, code[i]});
         chk({5'h00, limit_code[0]}, {5'h00, exp[i]});
      end
      chk({5'h00, limit_code[1]}, {5'h00, LIM_STATIC});
      chk({6'h00, range_pin_disable}, 8'h02);
      // Ch1 follows its pin, ch2 ignores it and keeps its high trim bit
      range_sel = 2'b01;
      repeat (3) @(negedge core_clk);
      chk({6'h00, high_range_sel}, 8'h03);
      range_sel = 2'b00;
      repeat (3) @(negedge core_clk);
      chk({6'h00, high_range_sel}, 8'h02);
   endtask : t_limit
   task automatic t_tone;
      for (int m = 0; m < 3; m++) begin
         xfer(1'b0, 2'b00, {3'b001, m[1:0], 3'b000});
         for (int p = 0; p < 4; p++) begin
            tone_22k = p[1];
            ext_mod = {1'b0, p[0]};
            repeat (3) @(negedge core_clk);
            chk(tone_drive[0], (m == 0) ? p[1] & p[0] : (m == 1) ? p[0] : p[1]);
         end
      end
      chk({6'h00, detect_threshold_choice}, 8'h02);
   endtask : t_tone
   task automatic t_refuse;
      undervoltage_lockout = 1'b0;
      xfer(1'b0, 2'b00, 8'h60);
      chk(ack_fail, 8'h01);
      undervoltage_lockout = 1'b1;
      xfer(1'b0, 2'b10, 8'h60);
      chk(ack_fail, 8'h01);
      chk({6'h00, channel_on}, 8'h03);
      xfer(1'b1, 2'b01, 8'h00);
      chk(rd_data, 8'h30);
   endtask : t_refuse
   initial begin
      sys_rst = 1'b1;
      repeat (5) @(negedge core_clk);
      sys_rst = 1'b0;
      t_reset();
      t_map();
      t_limit();
      t_tone();
      t_refuse();
      report_and_stop();
   end
   // Some 28 frames, 26 of 2000 clocks and 2 refused ones of 1100
   initial begin
      #8000000;
      err_count++;
      report_and_stop();
   end
endmodule : dual_lnb_i2c_register_port_tb
